//--- etm_port.sv
// external test master port of a jtag star multiplexer
// How it works
// - configuration mode feeds the arbitrated master into the internal tap
// - transparent mode passes the external or master 1 jtag to the selected port
// - external request low makes the external port the arbitrated master
// - configuration mode captures serial in on falling test clock edges
// - serial out changes on falling test clock edges, three-state pin
// - mode select sampled on rising test clock edges steps the tap
// - configure low plus request low opens the internal tap
// - configure input is ignored while the external request is high
// - five-bit active-low indicator shows the selected secondary port
// - periphery mode drives port pins from a boundary register
// - master 1 wins only when its request is low and external high
// - conflict output low when two or more requests are low
// - master 1 test reset low enters configuration only when arbitrated
`timescale 1ns/100ps
module etm_port
  import etm_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // external test master
  input  wire logic              ext_master_request_n,
  input  wire logic              ext_configure_n,
  input  wire logic              ext_test_clock,
  input  wire logic              ext_mode_select,
  input  wire logic              ext_serial_in,
  output logic                   ext_serial_out,
  output logic                   ext_serial_out_oe,
  // test master 1 and 2
  input  wire logic              master1_request_n,
  input  wire logic              master1_test_reset_n,
  input  wire etm_jtag_type      master1_jtag,
  output logic                   master1_serial_out,
  output logic                   master1_serial_out_oe,
  input  wire logic              master2_request_n,
  // global pins
  input  wire logic              output_float_n,
  input  wire logic              periphery_chain_reset_n,
  output logic                   master_conflict_n,
  output logic [SEL_W-1:0]       selected_port_indicator_n,
  // selected secondary port
  output etm_jtag_type           sec_jtag,
  input  wire logic              sec_serial_in,
  // general-purpose pins
  input  wire logic [3:0]        gpio_in,
  output logic [3:0]             gpio_out,
  output logic [3:0]             gpio_oe,
  // interrupt
  output logic                   irq
);

  // ==========================================================
  // pin synchronisers
  localparam int PIN_W = 18;

  logic [PIN_W-1:0] pin_s;
  logic             ext_master_request_n_n_s;
  logic             ext_configure_n_n_s;
  logic             ext_test_clock_s;
  logic             ext_mode_select_s;
  logic             ext_serial_in_s;
  logic             m1req_n_s;
  logic             m1trst_n_s;
  etm_jtag_type     m1_s;
  logic             m2req_n_s;
  logic             float_n_s;
  logic             periphery_chain_reset_n_n_s;
  logic             sec_tdo_s;
  logic [3:0]       gpio_s;

  etm_sync #(.W(PIN_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({ext_master_request_n, ext_configure_n, ext_test_clock,
               ext_mode_select, ext_serial_in, master1_request_n,
               master1_test_reset_n, master1_jtag, master2_request_n,
               output_float_n, periphery_chain_reset_n, sec_serial_in,
               gpio_in}),
    .q       (pin_s)
  );

  assign {ext_master_request_n_n_s, ext_configure_n_n_s, ext_test_clock_s, ext_mode_select_s, ext_serial_in_s, m1req_n_s,
          m1trst_n_s, m1_s, m2req_n_s, float_n_s, periphery_chain_reset_n_n_s,
          sec_tdo_s, gpio_s} = pin_s;

  // ==========================================================
  // arbitration and mode
  function automatic logic [1:0] count_low(input logic [2:0] req_n);
    count_low = {1'b0, ~req_n[0]} + {1'b0, ~req_n[1]} + {1'b0, ~req_n[2]};
  endfunction

  etm_master_type arb;
  etm_jtag_type   arb_jtag;
  logic           req_en;
  logic           cfg_mode;
  logic           conflict;

  // float pin disables every master request
  assign req_en = float_n_s;
  assign arb = !req_en          ? MST_NONE :
               !ext_master_request_n_n_s        ? MST_EXT  :
               !m1req_n_s       ? MST_M1   :
               !m2req_n_s       ? MST_M2   : MST_NONE;
  assign conflict = req_en &&
                    count_low({ext_master_request_n_n_s, m1req_n_s, m2req_n_s}) > 2'd1;
  // configure ignored unless external owns the port
  assign cfg_mode = (arb == MST_EXT && !ext_configure_n_n_s) ||
                    (arb == MST_M1 && !m1trst_n_s);
  assign arb_jtag = (arb == MST_EXT) ? {ext_test_clock_s, ext_mode_select_s, ext_serial_in_s} :
                    (arb == MST_M1)  ? m1_s : JTAG_IDLE;

  // ==========================================================
  // test clock edges
  logic tck_prev_r;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= arb_jtag.tck;
    end
  end

  assign tck_rise = arb_jtag.tck & ~tck_prev_r;
  assign tck_fall = ~arb_jtag.tck & tck_prev_r;

  // ==========================================================
  // tap state tracking
  etm_tap_type tap_state;
  logic        shifting;

  etm_tap_fsm u_tap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .step    (tck_rise),
    .tms     (arb_jtag.tms),
    .state_r (tap_state)
  );

  assign shifting = (tap_state == TAP_SHIFT_DR) ||
                    (tap_state == TAP_SHIFT_IR);

  // ==========================================================
  // configuration tap data path
  function automatic logic [SH_W-1:0] shift_in(input logic [SH_W-1:0] sh,
                                              input logic            bit_in,
                                              input int              len);
    logic [SH_W-1:0] v;
    v           = sh >> 1;
    v[len-1]    = bit_in;
    shift_in    = v;
  endfunction

  logic [SH_W-1:0]  sh_r;
  logic [IR_W-1:0]  ir_r;
  logic [SEL_W-1:0] sel_r;
  logic             cfg_fall;
  int               dr_len;

  assign cfg_fall = tck_fall && cfg_mode;
  assign dr_len   = (ir_r == IR_SELECT) ? SEL_W : 1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_r  <= '0;
      ir_r  <= IR_BYPASS;
      sel_r <= SEL_RST;
    end else if (cfg_fall) begin
      case (tap_state)
        TAP_RESET:    ir_r  <= IR_BYPASS;
        TAP_CAP_IR:   sh_r  <= {{(SH_W-IR_W){1'b0}}, IR_CAPTURE};
        TAP_CAP_DR:   sh_r  <= (ir_r == IR_SELECT) ?
                               {{(SH_W-SEL_W){1'b0}}, sel_r} : '0;
        TAP_SHIFT_IR: sh_r  <= shift_in(sh_r, arb_jtag.tdi, IR_W);
        TAP_SHIFT_DR: sh_r  <= shift_in(sh_r, arb_jtag.tdi, dr_len);
        TAP_UPD_IR:   ir_r  <= sh_r[IR_W-1:0];
        TAP_UPD_DR:   sel_r <= (ir_r == IR_SELECT) ? sh_r[SEL_W-1:0] : sel_r;
        default:      sh_r  <= sh_r;
      endcase
    end
  end

  // ==========================================================
  // registers written by software
  logic             pmode_r;
  logic [3:0]       gpio_out_r;
  logic [3:0]       gpio_dir_r;
  logic [2:0]       irq_en_r;
  logic [2:0]       irq_st_r;
  logic [7:0]       bscan_r;

  // ==========================================================
  // master-facing serial outputs
  logic tdo_bit;

  // internal tap in config mode, secondary port otherwise
  assign tdo_bit = cfg_mode ? sh_r[0] : sec_tdo_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_serial_out        <= 1'b0;
      ext_serial_out_oe     <= 1'b0;
      master1_serial_out    <= 1'b0;
      master1_serial_out_oe <= 1'b0;
    end else begin
      if (tck_fall && arb == MST_EXT) begin
        ext_serial_out <= tdo_bit;
      end
      if (tck_fall && arb == MST_M1) begin
        master1_serial_out <= tdo_bit;
      end
      ext_serial_out_oe     <= (arb == MST_EXT) && shifting;
      master1_serial_out_oe <= (arb == MST_M1) && shifting;
    end
  end

  // ==========================================================
  // secondary port, indicator, gpio and conflict pins
  etm_jtag_type sec_nxt;

  assign sec_nxt = pmode_r              ? etm_jtag_type'(bscan_r[7:5]) :
                   (cfg_mode || arb == MST_NONE) ? JTAG_IDLE :
                   arb_jtag;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_jtag                  <= JTAG_IDLE;
      selected_port_indicator_n <= ~SEL_RST;
      master_conflict_n         <= 1'b1;
      gpio_out                  <= GPIO_OUT_RST;
      gpio_oe                   <= GPIO_DIR_RST;
    end else begin
      sec_jtag                  <= sec_nxt;
      selected_port_indicator_n <= pmode_r ? ~bscan_r[SEL_W-1:0]
                                           : ~sel_r;
      master_conflict_n         <= ~conflict;
      gpio_out                  <= gpio_out_r;
      gpio_oe                   <= float_n_s ? gpio_dir_r : 4'h0;
    end
  end

  // ==========================================================
  // interrupt events
  logic [2:0] irq_ev;
  logic       conflict_prev_r;
  logic       cfg_prev_r;
  etm_master_type arb_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conflict_prev_r <= 1'b0;
      cfg_prev_r      <= 1'b0;
      arb_prev_r      <= MST_NONE;
    end else begin
      conflict_prev_r <= conflict;
      cfg_prev_r      <= cfg_mode;
      arb_prev_r      <= arb;
    end
  end

  assign irq_ev = {arb != arb_prev_r, cfg_mode & ~cfg_prev_r,
                   conflict & ~conflict_prev_r};

  // ==========================================================
  // axi4-lite slave
  logic [ADDR_W-1:0] awaddr_r;
  logic              aw_held_r;
  logic [31:0]       wdata_r;
  logic              w_held_r;
  logic              wr_go;
  logic              wr_hit;
  logic [2:0]        irq_clr;
  logic [31:0]       rd_val;
  logic              rd_hit;
  logic [31:0]       status_val;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go   = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_hit  = (awaddr_r == REG_CTRL) || (awaddr_r == REG_GPIO) ||
                   (awaddr_r == REG_IRQ_CLR) || (awaddr_r == REG_IRQ_EN) ||
                   (awaddr_r == REG_BSCAN);
  assign irq_clr = (wr_go && awaddr_r == REG_IRQ_CLR) ? wdata_r[2:0] : 3'h0;

  assign status_val = {19'h0, tap_state, sel_r, conflict, cfg_mode, arb};

  assign rd_hit = (s_axi_araddr == REG_CTRL)   ||
                  (s_axi_araddr == REG_GPIO)   ||
                  (s_axi_araddr == REG_STATUS) ||
                  (s_axi_araddr == REG_IRQ_ST) ||
                  (s_axi_araddr == REG_IRQ_EN) ||
                  (s_axi_araddr == REG_BSCAN);
  assign rd_val =
    (s_axi_araddr == REG_CTRL)   ? {31'h0, pmode_r} :
    (s_axi_araddr == REG_GPIO)   ? {20'h0, gpio_s, gpio_dir_r,
                                    gpio_out_r} :
    (s_axi_araddr == REG_STATUS) ? status_val :
    (s_axi_araddr == REG_IRQ_ST) ? {29'h0, irq_st_r} :
    (s_axi_araddr == REG_IRQ_EN) ? {29'h0, irq_en_r} :
    (s_axi_araddr == REG_BSCAN)  ? {24'h0, bscan_r} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= '0;
      wdata_r      <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes, byte lane 0 only carries fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pmode_r    <= 1'b0;
      gpio_out_r <= GPIO_OUT_RST;
      gpio_dir_r <= GPIO_DIR_RST;
      irq_en_r   <= IRQ_EN_RST;
      bscan_r    <= BSCAN_RST;
    end else if (wr_go) begin
      case (awaddr_r)
        REG_CTRL:   pmode_r    <= wdata_r[CTRL_PMODE_BIT];
        REG_GPIO: begin
          gpio_out_r <= wdata_r[GPIO_OUT_LSB +: 4];
          gpio_dir_r <= wdata_r[GPIO_DIR_LSB +: 4];
        end
        REG_IRQ_EN: irq_en_r   <= wdata_r[2:0];
        REG_BSCAN:  bscan_r    <= wdata_r[7:0];
        default:    pmode_r    <= pmode_r;
      endcase
    end
  end

  // sticky status, a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_r <= 3'h0;
      irq      <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
      irq      <= |(irq_st_r & irq_en_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- etm_pkg.sv
// constants and types for the external test master port
package etm_pkg;

  // ==========================================================
  // register map
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_GPIO    = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_IRQ_ST  = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_IRQ_EN  = 8'h14;
  localparam logic [7:0] REG_BSCAN   = 8'h18;

  // ==========================================================
  // field layout and reset values
  localparam int         CTRL_PMODE_BIT = 0;
  localparam int         GPIO_OUT_LSB   = 0;
  localparam int         GPIO_DIR_LSB   = 4;
  localparam int         GPIO_PIN_LSB   = 8;
  localparam logic [3:0] GPIO_DIR_RST   = 4'h0;
  localparam logic [3:0] GPIO_OUT_RST   = 4'h0;
  localparam logic [4:0] SEL_RST        = 5'h00;
  localparam logic [2:0] IRQ_EN_RST     = 3'h0;
  localparam logic [7:0] BSCAN_RST      = 8'h00;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ==========================================================
  // configuration tap instructions
  localparam int         IR_W       = 4;
  localparam int         SEL_W      = 5;
  localparam int         SH_W       = 8;
  localparam logic [3:0] IR_SELECT  = 4'h1;
  localparam logic [3:0] IR_BYPASS  = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MST_NONE, MST_EXT, MST_M1, MST_M2
  } etm_master_type;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
    TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } etm_tap_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } etm_jtag_type;

  localparam etm_jtag_type JTAG_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

endpackage

//--- etm_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module etm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

//--- etm_tap_fsm.sv
// ieee 1149.1 tap state machine, stepped by a clock-enable pulse
`timescale 1ns/100ps
module etm_tap_fsm
  import etm_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // stepping
  input  wire logic step,
  input  wire logic tms,
  // state
  output etm_tap_type state_r
);

  etm_tap_type state_nxt;

  always_comb begin
    case (state_r)
      TAP_RESET:    state_nxt = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     state_nxt = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   state_nxt = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   state_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_nxt = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_nxt = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_nxt = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   state_nxt = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   state_nxt = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   state_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_nxt = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_nxt = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_nxt = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   state_nxt = tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      state_nxt = TAP_RESET;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= TAP_RESET;
    end else if (step) begin
      state_r <= state_nxt;
    end
  end

endmodule

//--- etm_port_asserts.sv
// pin-level assertions for the external test master port
`timescale 1ns/100ps
module etm_port_asserts
  import etm_pkg::*;
(
  // clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // requests and external pins
  input wire logic         ext_master_request_n,
  input wire logic         ext_configure_n,
  input wire logic         ext_test_clock,
  input wire logic         ext_mode_select,
  input wire logic         ext_serial_in,
  input wire logic         ext_serial_out,
  input wire logic         ext_serial_out_oe,
  input wire logic         master1_request_n,
  input wire logic         master1_test_reset_n,
  input wire etm_jtag_type master1_jtag,
  input wire logic         master2_request_n,
  input wire logic         output_float_n,
  // watched outputs
  input wire logic         master_conflict_n,
  input wire etm_jtag_type sec_jtag,
  input wire logic [3:0]   gpio_oe
);
  // ==========
  // helpers
  etm_jtag_type ext_j;
  logic [1:0]   nreq;
  logic         multi;
  assign ext_j = {ext_test_clock, ext_mode_select, ext_serial_in};
  assign nreq = 2'(!ext_master_request_n) + 2'(!master1_request_n)
              + 2'(!master2_request_n);
  assign multi = output_float_n && nreq >= 2'h2;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // sequences and properties
  sequence s_ext_tr;
    (output_float_n && !ext_master_request_n && ext_configure_n
     && $stable(ext_j))[*8];
  endsequence
  sequence s_ext_cfg;
    (output_float_n && !ext_master_request_n && !ext_configure_n)[*8];
  endsequence
  sequence s_m1(logic rst_n);
    (output_float_n && ext_master_request_n && !master1_request_n
     && master1_test_reset_n == rst_n && $stable(master1_jtag))[*8];
  endsequence
  property p_conf_on; multi[*6] |-> !master_conflict_n; endproperty
  property p_conf_off; !multi[*6] |-> master_conflict_n; endproperty
  property p_ext_tr; s_ext_tr |-> sec_jtag == ext_j; endproperty
  property p_ext_cfg; s_ext_cfg |-> sec_jtag == JTAG_IDLE; endproperty
  property p_m1_tr; s_m1(1'b1) |-> sec_jtag == master1_jtag; endproperty
  property p_m1_cfg; s_m1(1'b0) |-> sec_jtag == JTAG_IDLE; endproperty
  property p_no_m1;
    (ext_master_request_n && master1_request_n)[*8]
      |-> sec_jtag == JTAG_IDLE;
  endproperty
  property p_oe_off;
    (ext_master_request_n || !output_float_n)[*6] |-> !ext_serial_out_oe;
  endproperty
  property p_tdo_fall;
    $changed(ext_serial_out) |-> !$past(ext_test_clock, 2);
  endproperty
  property p_gpio_rst; $rose(aresetn) |-> gpio_oe == 4'h0; endproperty
  a_conf_on: assert property (p_conf_on) else $error("no conflict");
  a_conf_off: assert property (p_conf_off) else $error("false conflict");
  a_ext_tr: assert property (p_ext_tr) else $error("ext route");
  a_ext_cfg: assert property (p_ext_cfg) else $error("cfg leak");
  a_m1_tr: assert property (p_m1_tr) else $error("m1 route");
  a_m1_cfg: assert property (p_m1_cfg) else $error("m1 cfg leak");
  a_no_m1: assert property (p_no_m1) else $error("stray route");
  a_oe_off: assert property (p_oe_off) else $error("tdo driven");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo edge");
  a_gpio_rst: assert property (p_gpio_rst) else $error("gpio dir");
endmodule

//--- etm_ext_master.sv
// behavioural external jtag test master
`timescale 1ns/100ps
module etm_ext_master (
  // clock
  input  wire logic aclk,
  // pins
  input  wire logic tdo_pin,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  // test clock stands low outside frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one test clock period of 32 aclk
  task automatic clk_bit(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (16) @(posedge aclk);
    tck <= 1'b1;
    q = tdo_pin;
    repeat (16) @(posedge aclk);
    tck <= 1'b0;
  endtask
endmodule

//--- tb.sv
// self-checking bench for the external test master port
`timescale 1ns/100ps
module tb
  import etm_pkg::*;
;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb, gpio_in, gpio_out, gpio_oe;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic         s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic         s_axi_arready, s_axi_rvalid, s_axi_rready, irq, tdo_pin;
  logic         ext_master_request_n, ext_configure_n, ext_test_clock;
  logic         ext_mode_select, ext_serial_in, ext_serial_out;
  logic         ext_serial_out_oe, master1_request_n, master1_test_reset_n;
  logic         master1_serial_out, master1_serial_out_oe, master2_request_n;
  logic         output_float_n, periphery_chain_reset_n, master_conflict_n;
  logic         sec_serial_in;
  logic [4:0]   selected_port_indicator_n;
  etm_jtag_type master1_jtag, sec_jtag;
  int           comparisons, miscompares;
  // tdo pin has a pull-up
  assign tdo_pin = ext_serial_out_oe ? ext_serial_out : 1'b1;
  etm_port u_dut (.*);
  etm_ext_master u_mst (
    .aclk    (aclk),
    .tdo_pin (tdo_pin),
    .tck     (ext_test_clock),
    .tms     (ext_mode_select),
    .tdi     (ext_serial_in)
  );
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ==========
  // tasks
  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic to(input int n);
    if (n >= 99) begin
      miscompares++;
      end_sim;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 99);
    to(n);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 99);
    to(n);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    chk("rdata", e, s_axi_rdata & m);
  endtask
  task automatic js(input logic [15:0] ms, d, input int n,
                    output logic [15:0] q);
    q = '0;
    for (int i = 0; i < n; i++) u_mst.clk_bit(ms[i], d[i], q[i]);
  endtask
  task automatic st;
    repeat (8) @(posedge aclk);
  endtask
  // ==========
  // main sequence
  initial begin
    logic [15:0] q;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sec_serial_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, output_float_n} = 3'h7;
    {ext_master_request_n, ext_configure_n, master2_request_n} = 3'h7;
    {master1_request_n, master1_test_reset_n} = 2'h3;
    {periphery_chain_reset_n, master1_jtag} = 4'hB;
    s_axi_wstrb = 4'hF;
    gpio_in = 4'h5;
    comparisons = 0;
    miscompares = 0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset pins", 32'hFC0, 32'({selected_port_indicator_n,
        master_conflict_n, irq, gpio_oe, ext_serial_out_oe}));
    rd(REG_GPIO, 32'hFF, 32'({GPIO_DIR_RST, GPIO_OUT_RST}), RESP_OKAY);
    rd(8'hFC, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(8'hFC, 32'h1, RESP_SLVERR);
    wr(REG_IRQ_EN, 32'h7, RESP_OKAY);
    master1_request_n <= 1'b0;
    ext_master_request_n <= 1'b0;
    st;
    chk("conflict irq", 32'h1, 32'({master_conflict_n, irq}));
    rd(REG_STATUS, 32'h3, 32'h1, RESP_OKAY);
    rd(REG_IRQ_ST, 32'h7, 32'h5, RESP_OKAY);
    master1_request_n <= 1'b1;
    wr(REG_IRQ_CLR, 32'h7, RESP_OKAY);
    st;
    rd(REG_IRQ_ST, 32'h7, 32'h0, RESP_OKAY);
    wr(REG_IRQ_EN, 32'h2, RESP_OKAY);
    master2_request_n <= 1'b0;
    st;
    rd(REG_IRQ_ST, 32'h1, 32'h1, RESP_OKAY);
    chk("masked irq", 32'h0, 32'(irq));
    master2_request_n <= 1'b1;
    wr(REG_IRQ_CLR, 32'h1, RESP_OKAY);
    ext_configure_n <= 1'b0;
    st;
    chk("config irq", 32'h1, 32'(irq));
    rd(REG_STATUS, 32'h4, 32'h4, RESP_OKAY);
    js(16'h00DF, 16'h0, 10, q);
    js(16'h0008, 16'(IR_SELECT), 4, q);
    chk("capture ir", 32'(IR_CAPTURE), 32'(q[3:0]));
    js(16'h0005, 16'h0, 5, q);
    js(16'h0010, 16'h13, 5, q);
    chk("select dr", 32'(SEL_RST), 32'(q[4:0]));
    js(16'h0001, 16'h0, 2, q);
    st;
    chk("indicator", 32'h0C, 32'(selected_port_indicator_n));
    chk("oe idle", 32'h0, 32'(ext_serial_out_oe));
    rd(REG_STATUS, 32'h1F0, 32'h130, RESP_OKAY);
    ext_configure_n <= 1'b1;
    st;
    rd(REG_STATUS, 32'h4, 32'h0, RESP_OKAY);
    js(16'h0001, 16'h0, 4, q);
    chk("tdo through", 32'h2, 32'({q[3], ext_serial_out_oe,
        master1_serial_out_oe}));
    js(16'h0003, 16'h0, 3, q);
    ext_master_request_n <= 1'b1;
    master1_request_n <= 1'b0;
    master1_jtag <= 3'h1;
    ext_configure_n <= 1'b0;
    st;
    rd(REG_STATUS, 32'h7, 32'h2, RESP_OKAY);
    master1_test_reset_n <= 1'b0;
    st;
    rd(REG_STATUS, 32'h7, 32'h6, RESP_OKAY);
    ext_master_request_n <= 1'b0;
    ext_configure_n <= 1'b1;
    st;
    rd(REG_STATUS, 32'h7, 32'h1, RESP_OKAY);
    wr(REG_BSCAN, 32'h5, RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    wr(REG_GPIO, 32'hFA, RESP_OKAY);
    @(posedge aclk);
    chk("gpio pins", 32'h1AFA, 32'({selected_port_indicator_n, gpio_oe,
        gpio_out}));
    rd(REG_GPIO, 32'hF00, 32'h500, RESP_OKAY);
    end_sim;
  end
endmodule
bind etm_port etm_port_asserts u_chk (.*);
